// *** core/sadc_ctrl.v ***
// Approximation sequencer for the converter plus two output converter channels.
// Assumes an external comparator answering whether the trial level is below the input,
// an analog over-range flag, and a register master on the same clock.
//
// How it works
// - In 8-bit mode the full 10-bit approximation register still runs and the result is its top eight bits.
// - An 8-bit conversion makes exactly eight comparisons, fixing bits 9 down to 2, each trial bit set first.
// - On completion of an 8-bit conversion the fixed bits land in bits 0 to 7 of the channel's result register.
// - An input above the reference saturates to the all-ones code.
// - The code count follows resolution: 1024 codes in 10-bit mode and 256 in 8-bit mode.
// - Each output channel holds an 8-bit data register setting its level in 256ths of the reference.
// - Any write to a channel's data register pulses that channel's start output one cycle before the written value reaches its code output.
// - A channel's analog pin is driven only while its output enable bit is one.
// - An enabled channel keeps driving until software clears its enable bit.
// - The reference-connection bit of the converter neither gates nor alters the output channels.
// - After reset both shared pins are undriven, floating inputs.
// - Each comparison keeps the trial bit when the trial level is below the input and clears it otherwise.
// - A conversion starts with the approximation register at its default, only the top bit set.
`include "sadc_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module sadc_ctrl #(
    parameter SADC_CHANNELS = 2
) (
    // Clock and reset.
    input  wire        clk_sys_in,
    input  wire        rst_in,
    // Register port.
    input  wire [3:0]  reg_addr_in,
    input  wire [15:0] reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [15:0] reg_rdata_out,
    // Comparator and over-range flag from the analog section.
    input  wire        cmp_level_below_in,
    input  wire        over_range_in,
    // Trial code to the internal level generator.
    output reg  [9:0]  trial_code_out,
    output reg         conv_done_out,
    // Output converter codes and start pulses.
    output reg  [7:0]  analog_output_pin_first_code_out,
    output reg  [7:0]  analog_output_pin_second_code_out,
    output reg         dac_start_first_out,
    output reg         dac_start_second_out,
    // Shared pin drive, enable low while driving.
    output reg         analog_output_pin_first_oe_n_out,
    output reg         analog_output_pin_second_oe_n_out
);

    localparam ST_IDLE = 1'b0;
    localparam ST_CONV = 1'b1;

    // Asynchronous pins pass three flip-flops; a change counts when stages two and three agree.
    reg [2:0] cmp_sync_reg;
    reg [2:0] ovr_sync_reg;
    reg       cmp_filt_reg;
    reg       ovr_filt_reg;

    reg        state_reg;
    reg [9:0]  sar_reg;
    reg [3:0]  bit_idx_reg;
    reg        res8_reg;
    reg        chan_reg;
    reg        vref_conn_reg;
    reg        conv_res8_reg;
    reg        conv_chan_reg;
    reg        ovr_seen_reg;
    reg [9:0]  result_reg [0:1];
    reg [7:0]  dac_data_reg [0:1];
    reg [1:0]  dac_en_reg;

    // True when a write strobe addresses the given register index.
    function sadc_wr_hit;
        input       wr;
        input [3:0] addr;
        input [3:0] target;
        begin
            sadc_wr_hit = wr && (addr == target);
        end
    endfunction

    // Write decodes, one per register that software can change.
    wire wr_ctrl  = sadc_wr_hit(reg_wr_in, reg_addr_in, `SADC_ADDR_CTRL);
    wire wr_dac0  = sadc_wr_hit(reg_wr_in, reg_addr_in, `SADC_ADDR_DAC0);
    wire wr_dac1  = sadc_wr_hit(reg_wr_in, reg_addr_in, `SADC_ADDR_DAC1);
    wire wr_dacen = sadc_wr_hit(reg_wr_in, reg_addr_in, `SADC_ADDR_DACEN);
    wire start_rq = wr_ctrl && reg_wdata_in[`SADC_CTRL_START_BIT];
    wire [3:0] last_bit = conv_res8_reg ? `SADC_LAST_BIT_8 : `SADC_LAST_BIT_10;

    // Returns a code with one bit set at the given index.
    function [9:0] sadc_onehot;
        input [3:0] idx;
        begin
            sadc_onehot = 10'h001 << idx;
        end
    endfunction

    // Synchronisers and agreement filter for the comparator and over-range inputs.
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cmp_sync_reg <= 3'h0;
            ovr_sync_reg <= 3'h0;
            cmp_filt_reg <= 1'b0;
            ovr_filt_reg <= 1'b0;
        end else begin
            cmp_sync_reg <= {cmp_sync_reg[1:0], cmp_level_below_in};
            ovr_sync_reg <= {ovr_sync_reg[1:0], over_range_in};
            if (cmp_sync_reg[1] == cmp_sync_reg[2]) begin
                cmp_filt_reg <= cmp_sync_reg[2];
            end
            if (ovr_sync_reg[1] == ovr_sync_reg[2]) begin
                ovr_filt_reg <= ovr_sync_reg[2];
            end
        end
    end

    // Control settings written by software.
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            res8_reg      <= 1'b0;
            chan_reg      <= 1'b0;
            vref_conn_reg <= 1'b0;
        end else if (wr_ctrl) begin
            res8_reg      <= reg_wdata_in[`SADC_CTRL_RES8_BIT];
            chan_reg      <= reg_wdata_in[`SADC_CTRL_CHAN_BIT];
            vref_conn_reg <= reg_wdata_in[`SADC_CTRL_VREF_BIT];
        end
    end

    // Successive approximation sequencer, one bit decision per clock.
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg      <= ST_IDLE;
            sar_reg        <= `SADC_SAR_DEFAULT;
            bit_idx_reg    <= 4'h9;
            conv_res8_reg  <= 1'b0;
            conv_chan_reg  <= 1'b0;
            ovr_seen_reg   <= 1'b0;
            conv_done_out  <= 1'b0;
            trial_code_out <= `SADC_SAR_DEFAULT;
            result_reg[0]  <= `SADC_RES_RESET;
            result_reg[1]  <= `SADC_RES_RESET;
        end else begin
            conv_done_out <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (start_rq) begin
                        state_reg      <= ST_CONV;
                        sar_reg        <= `SADC_SAR_DEFAULT;
                        trial_code_out <= `SADC_SAR_DEFAULT;
                        bit_idx_reg    <= 4'h9;
                        conv_res8_reg  <= reg_wdata_in[`SADC_CTRL_RES8_BIT];
                        conv_chan_reg  <= reg_wdata_in[`SADC_CTRL_CHAN_BIT];
                        ovr_seen_reg   <= 1'b0;
                    end
                end
                ST_CONV: begin
                    // Keep the trial bit when the level is below the input.
                    if (!cmp_filt_reg) begin
                        sar_reg[bit_idx_reg] <= 1'b0;
                    end
                    if (ovr_filt_reg) begin
                        ovr_seen_reg <= 1'b1;
                    end
                    if (bit_idx_reg == last_bit) begin
                        state_reg     <= ST_IDLE;
                        conv_done_out <= 1'b1;
                        if (ovr_seen_reg || ovr_filt_reg) begin
                            result_reg[conv_chan_reg] <= conv_res8_reg ?
                                `SADC_SAR_FULL8 : `SADC_SAR_FULL;
                        end else if (conv_res8_reg) begin
                            // Top eight bits go to the low byte.
                            result_reg[conv_chan_reg] <= {2'b00, sar_reg[9:3],
                                cmp_filt_reg};
                        end else begin
                            result_reg[conv_chan_reg] <= {sar_reg[9:1], cmp_filt_reg};
                        end
                    end else begin
                        // Set the next trial bit before it is compared.
                        sar_reg[bit_idx_reg - 4'h1] <= 1'b1;
                        trial_code_out <= (cmp_filt_reg ? sar_reg :
                            (sar_reg & ~sadc_onehot(bit_idx_reg)))
                            | sadc_onehot(bit_idx_reg - 4'h1);
                        bit_idx_reg <= bit_idx_reg - 4'h1;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Output converter data, enables and start pulses.
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            dac_data_reg[0]      <= `SADC_DAC_RESET;
            dac_data_reg[1]      <= `SADC_DAC_RESET;
            dac_en_reg           <= 2'b00;
            dac_start_first_out  <= 1'b0;
            dac_start_second_out <= 1'b0;
        end else begin
            // Every data write restarts its channel, even with an unchanged value.
            dac_start_first_out  <= wr_dac0;
            dac_start_second_out <= wr_dac1;
            if (wr_dac0) begin
                dac_data_reg[0] <= reg_wdata_in[7:0];
            end
            if (wr_dac1) begin
                dac_data_reg[1] <= reg_wdata_in[7:0];
            end
            // Enables change only by software write.
            if (wr_dacen) begin
                dac_en_reg <= reg_wdata_in[1:0];
            end
        end
    end

    // Pin drive follows enables only; the reference-connection bit plays no part.
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            analog_output_pin_first_oe_n_out  <= 1'b1;
            analog_output_pin_second_oe_n_out <= 1'b1;
            analog_output_pin_first_code_out  <= `SADC_DAC_RESET;
            analog_output_pin_second_code_out <= `SADC_DAC_RESET;
        end else begin
            analog_output_pin_first_oe_n_out  <= ~dac_en_reg[`SADC_DACEN_CH0_BIT];
            analog_output_pin_second_oe_n_out <= ~dac_en_reg[`SADC_DACEN_CH1_BIT];
            analog_output_pin_first_code_out  <= dac_data_reg[0];
            analog_output_pin_second_code_out <= dac_data_reg[1];
        end
    end

    // Read data, one cycle after the read strobe; unmapped reads return zero.
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `SADC_ADDR_CTRL:    reg_rdata_out <= {12'h000, vref_conn_reg, chan_reg,
                                                      res8_reg, 1'b0};
                `SADC_ADDR_STATUS:  reg_rdata_out <= {14'h0000, 1'b0, state_reg};
                `SADC_ADDR_RESULT0: reg_rdata_out <= {6'h00, result_reg[0]};
                `SADC_ADDR_RESULT1: reg_rdata_out <= {6'h00, result_reg[1]};
                `SADC_ADDR_DAC0:    reg_rdata_out <= {8'h00, dac_data_reg[0]};
                `SADC_ADDR_DAC1:    reg_rdata_out <= {8'h00, dac_data_reg[1]};
                `SADC_ADDR_DACEN:   reg_rdata_out <= {14'h0000, dac_en_reg};
                default:            reg_rdata_out <= 16'h0000;
            endcase
        end else begin
            reg_rdata_out <= 16'h0000;
        end
    end

endmodule // sadc_ctrl

`default_nettype wire

// *** core/sadc_defs.vh ***
// Constants for the 10-bit approximation control with its 8-bit mode, and the two-channel output converter.
// Assumes inclusion by the design, checker and bench files; holds definitions only.
`ifndef SADC_DEFS_VH
`define SADC_DEFS_VH

// Register indices on the plain register port (word addresses).
`define SADC_ADDR_CTRL      4'h0
`define SADC_ADDR_STATUS    4'h1
`define SADC_ADDR_RESULT0   4'h2
`define SADC_ADDR_RESULT1   4'h3
`define SADC_ADDR_DAC0      4'h4
`define SADC_ADDR_DAC1      4'h5
`define SADC_ADDR_DACEN     4'h6
`define SADC_ADDR_WIDTH     4

// Control register fields.
`define SADC_CTRL_START_BIT 0
`define SADC_CTRL_RES8_BIT  1
`define SADC_CTRL_CHAN_BIT  2
`define SADC_CTRL_VREF_BIT  3

// Status register fields.
`define SADC_STAT_BUSY_BIT  0
`define SADC_STAT_DONE_BIT  1

// Output enable register fields.
`define SADC_DACEN_CH0_BIT  0
`define SADC_DACEN_CH1_BIT  1

// Approximation register default: only the top bit set.
`define SADC_SAR_DEFAULT    10'h200
`define SADC_SAR_FULL       10'h3ff
`define SADC_SAR_FULL8      10'h0ff
`define SADC_RES_RESET      10'h000
`define SADC_DAC_RESET      8'h00

// Lowest bit fixed in each resolution.
`define SADC_LAST_BIT_10    4'h0
`define SADC_LAST_BIT_8     4'h2

`endif

// *** sim/sadc_ctrl_chk.sv ***
// Port checker for the approximation sequencer and the two output channels.
// Assumes it is bound to each instance of the control block.
`include "sadc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module sadc_ctrl_chk (
    // Clock and reset.
    input wire logic        clk_sys_in,
    input wire logic        rst_in,
    // Register port.
    input wire logic [3:0]  reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic        reg_wr_in,
    // Converter and channel outputs.
    input wire logic [9:0]  trial_code_out,
    input wire logic        conv_done_out,
    input wire logic [7:0]  analog_output_pin_first_code_out,
    input wire logic        dac_start_first_out,
    input wire logic        dac_start_second_out,
    input wire logic        analog_output_pin_first_oe_n_out
);
    logic run_reg;
    logic run_next;
    wire  start_acc = reg_wr_in && reg_addr_in == `SADC_ADDR_CTRL && reg_wdata_in[0]
                      && (!run_reg || conv_done_out);
    // Tracks a conversion in flight, so that refused starts are not timed.
    always_comb run_next = start_acc ? 1'b1 : (conv_done_out ? 1'b0 : run_reg);
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in)
            run_reg <= 1'b0;
        else
            run_reg <= run_next;
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    done_one_cycle_a: assert property (conv_done_out |=> !conv_done_out)
        else $error("done pulse longer than one cycle");
    conv_eight_a: assert property (start_acc && reg_wdata_in[1] |=>
        !conv_done_out[*8] ##1 conv_done_out) else $error("8-bit conversion length wrong");
    conv_ten_a: assert property (start_acc && !reg_wdata_in[1] |-> ##3
        !conv_done_out[*8] ##1 conv_done_out) else $error("10-bit conversion length wrong");
    trial_default_a: assert property (start_acc |=>
        trial_code_out == `SADC_SAR_DEFAULT) else $error("trial code not at default");
    start_first_a: assert property (reg_wr_in && reg_addr_in == `SADC_ADDR_DAC0 |=>
        dac_start_first_out) else $error("first channel not started");
    start_second_a: assert property (reg_wr_in && reg_addr_in == `SADC_ADDR_DAC1 |=>
        dac_start_second_out) else $error("second channel not started");
    code_follow_a: assert property (reg_wr_in && reg_addr_in == `SADC_ADDR_DAC0 |-> ##2
        analog_output_pin_first_code_out == $past(reg_wdata_in[7:0], 2))
        else $error("channel code differs from written value");
    oe_follow_a: assert property (reg_wr_in && reg_addr_in == `SADC_ADDR_DACEN |-> ##2
        analog_output_pin_first_oe_n_out == !$past(reg_wdata_in[0], 2))
        else $error("pin drive does not follow enable");
    oe_hold_a: assert property ($changed(analog_output_pin_first_oe_n_out) |->
        $past(reg_wr_in && reg_addr_in == `SADC_ADDR_DACEN, 2))
        else $error("pin drive changed without enable write");
endmodule // sadc_ctrl_chk
bind sadc_ctrl sadc_ctrl_chk sadc_ctrl_chk_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .trial_code_out(trial_code_out), .conv_done_out(conv_done_out),
    .analog_output_pin_first_code_out(analog_output_pin_first_code_out),
    .dac_start_first_out(dac_start_first_out), .dac_start_second_out(dac_start_second_out),
    .analog_output_pin_first_oe_n_out(analog_output_pin_first_oe_n_out));
`default_nettype wire

// *** sim/sadc_ctrl_tb.sv ***
// Self-checking bench for the converter control block.
// Assumes a static comparator level held well beyond the synchroniser delay.
`include "sadc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module sadc_ctrl_tb;
    logic        clk_sys_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [3:0]  reg_addr_in = 4'h0;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic        cmp_in = 1'b0;
    logic        ovr_in = 1'b0;
    logic [15:0] reg_rdata_out;
    logic        conv_done_out;
    logic        oe_first_n;
    logic        oe_second_n;
    logic [7:0]  code_first;
    logic [7:0]  code_second;
    logic        rd_seen = 1'b0;
    logic [15:0] exp_q[$];
    logic [7:0]  d0;
    logic [7:0]  d1;
    int          miscompares = 0;
    int          checks_done = 0;
    int          seed_use;
    sadc_ctrl sadc_ctrl_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .cmp_level_below_in(cmp_in), .over_range_in(ovr_in),
        .trial_code_out(), .conv_done_out(conv_done_out),
        .analog_output_pin_first_code_out(code_first),
        .analog_output_pin_second_code_out(code_second),
        .dac_start_first_out(), .dac_start_second_out(),
        .analog_output_pin_first_oe_n_out(oe_first_n),
        .analog_output_pin_second_oe_n_out(oe_second_n));
    // Free-running system clock.
    always #5 clk_sys_in = ~clk_sys_in;
    task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: pin %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_code(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: code %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_sys_in);
        reg_rd_in   <= 1'b0;
    endtask
    // Starts a conversion at a fixed analog level and reads back its result.
    task automatic conv(input logic [15:0] c, input logic lv, input logic ov, input logic [15:0] e);
        int n;
        n = 0;
        cmp_in <= lv;
        ovr_in <= ov;
        repeat (6) @(posedge clk_sys_in);
        wr(`SADC_ADDR_CTRL, c);
        while (conv_done_out !== 1'b1 && n < 20) begin
            @(negedge clk_sys_in);
            n++;
        end
        chk_pin(conv_done_out, 1'b1);
        rd(c[2] ? `SADC_ADDR_RESULT1 : `SADC_ADDR_RESULT0, e);
    endtask
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Read data stand one cycle after the strobe; compare them mid-cycle.
    always @(posedge clk_sys_in) rd_seen <= reg_rd_in;
    always @(negedge clk_sys_in) begin
        if (rd_seen)
            chk_rd(reg_rdata_out, exp_q.pop_front());
    end
    // Main sequence: reset state, conversions, then the output channels.
    initial begin
        seed_use = $urandom(32'ha5d74972);
        repeat (8) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        chk_pin(oe_first_n, 1'b1);
        chk_pin(oe_second_n, 1'b1);
        rd(`SADC_ADDR_DACEN, 16'h0000);
        rd(4'hf, 16'h0000);
        conv(16'h0003, 1'b1, 1'b0, 16'h00ff);
        conv(16'h0007, 1'b0, 1'b0, 16'h0000);
        rd(`SADC_ADDR_RESULT0, 16'h00ff);
        conv(16'h0001, 1'b1, 1'b0, 16'h03ff);
        conv(16'h000b, 1'b0, 1'b1, 16'h00ff);
        conv(16'h0005, 1'b0, 1'b1, 16'h03ff);
        // Both shared pins are set to drive here, then the reference-connection bit is set.
        d0 = 8'($urandom());
        d1 = 8'($urandom());
        wr(`SADC_ADDR_DAC0, {8'h00, d0});
        wr(`SADC_ADDR_DAC1, {8'h00, d1});
        wr(`SADC_ADDR_DACEN, 16'h0003);
        wr(`SADC_ADDR_CTRL, 16'h0008);
        rd(`SADC_ADDR_DAC0, {8'h00, d0});
        rd(`SADC_ADDR_DAC1, {8'h00, d1});
        chk_code(code_first, d0);
        chk_code(code_second, d1);
        chk_pin(oe_first_n, 1'b0);
        chk_pin(oe_second_n, 1'b0);
        wr(`SADC_ADDR_DAC0, {8'h00, ~d0});
        wr(`SADC_ADDR_DACEN, 16'h0002);
        repeat (2) @(negedge clk_sys_in);
        chk_pin(oe_first_n, 1'b1);
        chk_pin(oe_second_n, 1'b0);
        rd(`SADC_ADDR_DAC0, {8'h00, ~d0});
        chk_code(code_first, ~d0);
        repeat (2) @(posedge clk_sys_in);
        finish_test();
    end
    // Watchdog at 2000 cycles, well beyond the fewer than 150 cycles the sequence needs.
    initial begin
        #20000;
        miscompares++;
        finish_test();
    end
endmodule // sadc_ctrl_tb
`default_nettype wire
